// *** hw/bioc_pkg.sv ***
/*
  constants for the bytewise port block: data-space offsets, reset
  values, pin availability masks and trigger mode codes.
  assumes the core data-space bus is byte wide with 8-bit addresses.
*/
package bioc_pkg;
  localparam logic [7:0] BIOC_DATA_A = 8'hc0;
  localparam logic [7:0] BIOC_DATA_B = 8'hc1;
  localparam logic [7:0] BIOC_DATA_C = 8'hc3;
  localparam logic [7:0] BIOC_DIR_A = 8'hc4;
  localparam logic [7:0] BIOC_DIR_B = 8'hc5;
  localparam logic [7:0] BIOC_DIR_C = 8'hc6;
  localparam logic [7:0] BIOC_OPT_A = 8'hcc;
  localparam logic [7:0] BIOC_OPT_B = 8'hce;
  localparam logic [7:0] BIOC_OPT_C = 8'hcf;
  localparam logic [7:0] BIOC_REG_RST = 8'h00;
  // implemented lines per port (a0, a1 absent)
  localparam logic [7:0] BIOC_IMPL_A = 8'hfc;
  localparam logic [7:0] BIOC_IMPL_B = 8'hff;
  localparam logic [7:0] BIOC_IMPL_C = 8'hff;
  // analog-capable lines
  localparam logic [7:0] BIOC_ANA_A = 8'h00;
  localparam logic [7:0] BIOC_ANA_B = 8'hff;
  localparam logic [7:0] BIOC_ANA_C = 8'hf0;
  // high-current sink lines
  localparam logic [7:0] BIOC_HSNK_A = 8'hfc;
  localparam logic [7:0] BIOC_HSNK_B = 8'h00;
  localparam logic [7:0] BIOC_HSNK_C = 8'h0f;
  // fixed line positions of alternate functions and converter multiplexer select width
  localparam int BIOC_PWM_BIT = 7;
  localparam int BIOC_TXD_BIT = 0;
  localparam int BIOC_SOUT_BIT = 7;
  localparam int BIOC_MUX_W = 5;
  typedef enum logic [1:0] {
    BIOC_TRIG_FALL = 2'b00,
    BIOC_TRIG_RISE = 2'b01,
    BIOC_TRIG_LOW = 2'b10
  } bioc_trig_t;
endpackage

// *** hw/bioc_line.sv ***
/*
  one port line: decodes direction, option and data latch into the
  pin drive, pull-up, interrupt and analog selects, and the read value.
  assumes the caller registers the results.
*/
`timescale 1ns/100ps
module bioc_line (
  input wire logic dir,
  input wire logic opt,
  input wire logic dat,
  input wire logic pin_in,
  input wire logic alt_en,
  input wire logic alt_val,
  input wire logic alt_od_only,
  input wire logic ana_ok,
  input wire logic impl,
  output logic drv_low,
  output logic pu_en,
  output logic irq_sel,
  output logic ana_sel,
  output logic rd_bit
);
  logic lvl;
  always_comb begin
    lvl = dat;
    if (alt_en && (!alt_od_only || !opt)) begin
      lvl = alt_val;
    end
    drv_low = 1'b0;
    pu_en = 1'b0;
    irq_sel = 1'b0;
    ana_sel = 1'b0;
    if (!impl) begin
      drv_low = 1'b0;
    end else if (dir || (alt_en && !alt_od_only)) begin
      // push-pull and open-drain both sink on low
      drv_low = !lvl;
    end else begin
      pu_en = !dat;
      irq_sel = opt && !dat;
      ana_sel = opt && dat && ana_ok;
    end
    // input reads the pin, output reads the latch
    rd_bit = impl ? (dir ? dat : pin_in) : 1'b0;
  end
endmodule // bioc_line

// *** hw/bioc_port.sv ***
/*
  bytewise i/o ports a, b and c behind the core data-space bus.
  assumes a single-cycle byte bus: address, write strobe and data
  are valid together; read data is registered one cycle later. pad
  cells turn drive_low_n, push_pull and pull_up into pin levels.
*/
// Notes on behaviour
// - input decode: pull-up, plain, interrupt, analog
// - output: option chooses open-drain or push-pull
// - analog input routed to converter multiplexer
// - input-mode data read returns pin level
// - data latch still sets input characteristics
// - high sink only on a2-a7, c0-c3
// - pwm enable forces pwm onto b7
// - serial inputs stay readable any input mode
// - serial out only in open-drain mode
// - uart receive readable independent of uart
// - uart transmit shows latch when idle
// - option and direction registers eight-bit rw
// - reset clears all port registers
// - interrupt lines feed per-port trigger logic
`timescale 1ns/100ps
module bioc_port
  import bioc_pkg::*;
#(
  parameter int NPORT = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic [23:0] pin_in,
  output logic [23:0] drive_low_n,
  output logic [23:0] push_pull,
  output logic [23:0] pull_up,
  output logic [23:0] high_sink,
  output logic [23:0] analog_sel,
  output logic [2:0] port_irq,
  input wire logic [5:0] irq_trig_mode,
  input wire logic pwm_pin_output_enable,
  input wire logic pwm_level,
  input wire logic serial_out_level,
  input wire logic uart_tx_active,
  input wire logic uart_tx_level,
  output logic [4:0] adc_mux_sel,
  output logic adc_mux_valid
);
  // ==========================================================
  // registers
  logic [7:0] dat_reg [NPORT];
  logic [7:0] dir_reg [NPORT];
  logic [7:0] opt_reg [NPORT];
  logic [7:0] pin_prev_reg [NPORT];
  logic [7:0] rd_bits [NPORT];
  logic [7:0] irq_bits [NPORT];
  logic [23:0] drv_low_next, pu_next, ana_next;
  localparam logic [7:0] DAT_ADDR [3] = '{BIOC_DATA_A, BIOC_DATA_B,
    BIOC_DATA_C};
  localparam logic [7:0] DIR_ADDR [3] = '{BIOC_DIR_A, BIOC_DIR_B,
    BIOC_DIR_C};
  localparam logic [7:0] OPT_ADDR [3] = '{BIOC_OPT_A, BIOC_OPT_B,
    BIOC_OPT_C};
  localparam logic [7:0] IMPL [3] = '{BIOC_IMPL_A, BIOC_IMPL_B,
    BIOC_IMPL_C};
  localparam logic [7:0] ANA [3] = '{BIOC_ANA_A, BIOC_ANA_B, BIOC_ANA_C};
  localparam logic [7:0] HSNK [3] = '{BIOC_HSNK_A, BIOC_HSNK_B,
    BIOC_HSNK_C};

  // ==========================================================
  // per port registers and lines
  genvar p, b;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          dat_reg[p] <= BIOC_REG_RST;
          dir_reg[p] <= BIOC_REG_RST;
          opt_reg[p] <= BIOC_REG_RST;
        end else if (bus_wr) begin
          // writes always hit the latch, even in input mode
          if (bus_addr == DAT_ADDR[p]) dat_reg[p] <= bus_wdata;
          if (bus_addr == DIR_ADDR[p]) dir_reg[p] <= bus_wdata;
          if (bus_addr == OPT_ADDR[p]) opt_reg[p] <= bus_wdata;
        end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          pin_prev_reg[p] <= 8'hff;
        end else begin
          pin_prev_reg[p] <= pin_in[p*8 +: 8];
        end
      end
      for (b = 0; b < 8; b++) begin : g_bit
        logic alt_en, alt_val, alt_od;
        always_comb begin
          alt_en = 1'b0;
          alt_val = 1'b1;
          alt_od = 1'b0;
          if (p == 1 && b == BIOC_PWM_BIT) begin
            alt_en = pwm_pin_output_enable;
            alt_val = pwm_level;
          end else if (p == 0 && b == BIOC_SOUT_BIT) begin
            alt_en = dir_reg[p][b];
            alt_val = serial_out_level;
            alt_od = 1'b1;
          end else if (p == 1 && b == BIOC_TXD_BIT) begin
            // uart owns the line in either output mode while it sends
            alt_en = dir_reg[p][b] && uart_tx_active;
            alt_val = uart_tx_level;
          end
        end
        bioc_line u_line (
          .dir(dir_reg[p][b]),
          .opt(opt_reg[p][b]),
          .dat(dat_reg[p][b]),
          .pin_in(pin_in[p*8+b]),
          .alt_en(alt_en),
          .alt_val(alt_val),
          .alt_od_only(alt_od),
          .ana_ok(ANA[p][b]),
          .impl(IMPL[p][b]),
          .drv_low(drv_low_next[p*8+b]),
          .pu_en(pu_next[p*8+b]),
          .irq_sel(irq_bits[p][b]),
          .ana_sel(ana_next[p*8+b]),
          .rd_bit(rd_bits[p][b])
        );
      end
    end
  endgenerate

  // ==========================================================
  // pad controls, registered
  logic [23:0] pp_next, hs_next;
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pp_next[i] = dir_reg[i/8][i%8] && opt_reg[i/8][i%8];
      hs_next[i] = dir_reg[i/8][i%8] && HSNK[i/8][i%8];
    end
    // pwm alternate overrides the pad mode; serial out keeps it
    if (pwm_pin_output_enable) pp_next[8+BIOC_PWM_BIT] = 1'b1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drive_low_n <= '1;
      push_pull <= '0;
      pull_up <= '1;
      high_sink <= '0;
      analog_sel <= '0;
    end else begin
      drive_low_n <= ~drv_low_next;
      push_pull <= pp_next;
      pull_up <= pu_next;
      high_sink <= hs_next;
      analog_sel <= ana_next;
    end
  end

  // ==========================================================
  // converter multiplexer: lowest selected line wins
  logic [4:0] mux_next;
  logic mux_hit;
  always_comb begin
    mux_next = '0;
    mux_hit = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      if (ana_next[i]) begin
        mux_next = 5'(i);
        mux_hit = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      adc_mux_sel <= '0;
      adc_mux_valid <= 1'b0;
    end else begin
      adc_mux_sel <= mux_next;
      adc_mux_valid <= mux_hit;
    end
  end

  // ==========================================================
  // per-port interrupt request, trigger mode per port
  logic [2:0] irq_next;
  always_comb begin
    for (int q = 0; q < 3; q++) begin
      logic [7:0] cur;
      logic [7:0] prv;
      cur = pin_in[q*8 +: 8];
      prv = pin_prev_reg[q];
      unique case (bioc_trig_t'(irq_trig_mode[q*2 +: 2]))
        BIOC_TRIG_FALL: irq_next[q] = |(irq_bits[q] & prv & ~cur);
        BIOC_TRIG_RISE: irq_next[q] = |(irq_bits[q] & ~prv & cur);
        BIOC_TRIG_LOW: irq_next[q] = |(irq_bits[q] & ~cur);
        default: irq_next[q] = 1'b0;
      endcase
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) port_irq <= '0;
    else port_irq <= irq_next;
  end

  // ==========================================================
  // read path
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata <= '0;
    end else if (bus_rd) begin
      bus_rdata <= '0;
      for (int q = 0; q < 3; q++) begin
        if (bus_addr == DAT_ADDR[q]) bus_rdata <= rd_bits[q];
        if (bus_addr == DIR_ADDR[q]) bus_rdata <= dir_reg[q];
        if (bus_addr == OPT_ADDR[q]) bus_rdata <= opt_reg[q];
      end
    end
  end

  // ==========================================================
  // checks
  // read and write strobes whose answer is known from the line setup
  sequence s_read_input_b;
    bus_rd && bus_addr == BIOC_DATA_B && dir_reg[1] == 8'h00;
  endsequence
  sequence s_read_output_c;
    bus_rd && bus_addr == BIOC_DATA_C && dir_reg[2] == 8'hff;
  endsequence
  sequence s_write_dir_c;
    bus_wr && bus_addr == BIOC_DIR_C;
  endsequence
  // falling edge on b2 while it is an interrupt input
  sequence s_fall_on_b2;
    irq_trig_mode[3:2] == 2'b00 && !dir_reg[1][2] && opt_reg[1][2]
    && !dat_reg[1][2] && $past(pin_in[10]) && !pin_in[10];
  endsequence

  a_read_input_pin: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_read_input_b |=> bus_rdata == $past(pin_in[15:8]))
    else $error("input read not pin level");

  a_read_output_latch: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_read_output_c |=> bus_rdata == $past(dat_reg[2]))
    else $error("output read not latch");

  a_dir_write_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_write_dir_c |=> dir_reg[2] == $past(bus_wdata))
    else $error("direction write lost");

  a_pwm_drive: assert property (
    @(posedge clk_sys) disable iff (rst)
    pwm_pin_output_enable |=> drive_low_n[15] == $past(pwm_level))
    else $error("pwm not on line");

  // a0, a1, all of port b and c4-c7 never sink high current
  a_high_sink_map: assert property (
    @(posedge clk_sys) disable iff (rst)
    (high_sink & 24'hf0ff03) == 24'h000000)
    else $error("high sink on wrong line");

  a_input_pullup: assert property (
    @(posedge clk_sys) disable iff (rst)
    !dir_reg[2][4] && !dat_reg[2][4] |=> pull_up[20])
    else $error("pull-up missing");

  a_input_released: assert property (
    @(posedge clk_sys) disable iff (rst)
    !dir_reg[2][1] |=> drive_low_n[17] && !push_pull[17])
    else $error("input line driven");

  a_od_no_push: assert property (
    @(posedge clk_sys) disable iff (rst)
    dir_reg[2][0] && !opt_reg[2][0] |=> !push_pull[16])
    else $error("open-drain line pushes high");

  a_analog_route: assert property (
    @(posedge clk_sys) disable iff (rst)
    ana_next == 24'h000800 |=> adc_mux_valid && adc_mux_sel == 5'h0b)
    else $error("analog not routed");

  a_irq_fall: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_fall_on_b2 |=> port_irq[1])
    else $error("falling edge lost");

  a_tx_idle_latch: assert property (
    @(posedge clk_sys) disable iff (rst)
    dir_reg[1][0] && !uart_tx_active
    |=> drive_low_n[8] == $past(dat_reg[1][0]))
    else $error("tx idle not latch");

  a_sout_pushpull: assert property (
    @(posedge clk_sys) disable iff (rst)
    dir_reg[0][7] && opt_reg[0][7]
    |=> drive_low_n[7] == $past(dat_reg[0][7]))
    else $error("serial out in push-pull");

  a_reset_clear: assert property (
    @(posedge clk_sys)
    $fell(rst) |-> dir_reg[0] == 8'h00 && opt_reg[0] == 8'h00)
    else $error("reset not cleared");
endmodule // bioc_port

// *** tb/bioc_pins.sv ***
/*
  pin model for the bytewise port block: resolves the pad controls and
  an outside driver into pin levels fed back to the block.
  assumes one clock; a line nobody drives changes level every cycle.
*/
`timescale 1ns/100ps
module bioc_pins (
  input wire logic clk_sys,
  input wire logic [23:0] drive_low_n,
  input wire logic [23:0] push_pull,
  input wire logic [23:0] pull_up,
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  output logic [23:0] pin_level
);
  logic [23:0] last_reg = '0;
  // ==========
  // resolution
  // outside driver beats the weak pull-up; a floating line toggles so
  // a stale level never passes for a match
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (!drive_low_n[i])
        pin_level[i] = 1'b0;
      else if (push_pull[i])
        pin_level[i] = 1'b1;
      else if (ext_en[i])
        pin_level[i] = ext_val[i];
      else if (pull_up[i])
        pin_level[i] = 1'b1;
      else
        pin_level[i] = ~last_reg[i];
    end
  end
  always_ff @(posedge clk_sys) begin
    last_reg <= pin_level;
  end
endmodule // bioc_pins

// *** tb/test_bytewise_io_port_config.sv ***
/*
  self-checking bench for the bytewise port block.
  assumes the pin model bioc_pins and a 50 MHz core clock.
*/
`timescale 1ns/100ps
module test_bytewise_io_port_config;
  import bioc_pkg::*;
  // =======
  // signals
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [7:0] bus_rdata;
  logic [23:0] pin_in, drive_low_n, push_pull, pull_up;
  logic [23:0] high_sink, analog_sel;
  logic [2:0] port_irq;
  logic [5:0] irq_trig_mode = 6'h3f;
  logic pwm_en = 1'b0, pwm_lvl = 1'b0, sout = 1'b0;
  logic tx_act = 1'b0, tx_lvl = 1'b0;
  logic [4:0] adc_mux_sel;
  logic adc_mux_valid;
  logic [23:0] ext_en = 24'h0, ext_val = 24'h0;
  logic [7:0] regs [6] = '{BIOC_DIR_A, BIOC_DIR_B, BIOC_DIR_C,
                           BIOC_OPT_A, BIOC_OPT_B, BIOC_OPT_C};
  int fails = 0;
  int check_count = 0;

  always #10 clk_sys = ~clk_sys;

  bioc_port uut (.clk_sys, .rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
    .bus_rdata, .pin_in, .drive_low_n, .push_pull, .pull_up, .high_sink,
    .analog_sel, .port_irq, .irq_trig_mode, .pwm_pin_output_enable(pwm_en),
    .pwm_level(pwm_lvl), .serial_out_level(sout), .uart_tx_active(tx_act),
    .uart_tx_level(tx_lvl), .adc_mux_sel, .adc_mux_valid);
  bioc_pins pins (.clk_sys, .drive_low_n, .push_pull, .pull_up, .ext_en,
    .ext_val, .pin_level(pin_in));

  // =====
  // tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // whole-byte writes only, never read-modify-write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk_sys);
    bus_wr = 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(negedge clk_sys);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk_sys);
    bus_rd = 1'b0;
    chk(what, 24'(exp), 24'(bus_rdata));
  endtask
  task automatic wirq(input logic exp, input string what);
    logic hit;
    hit = 1'b0;
    repeat (6) begin
      @(negedge clk_sys);
      if (port_irq[1] === 1'b1)
        hit = 1'b1;
    end
    chk(what, 24'(exp), 24'(hit));
  endtask
  task automatic do_reset;
    @(negedge clk_sys);
    rst = 1'b1;
    idle(8);
    rst = 1'b0;
    idle(1);
  endtask

  // =========
  // scenarios
  task automatic t_reset;
    chk("pull_up", 24'hfffffc, pull_up);
    chk("drive_low_n", 24'hffffff, drive_low_n);
    chk("push_pull", 24'h0, push_pull);
    foreach (regs[i]) rc(regs[i], 8'h00, "reg reset");
  endtask
  task automatic t_regs;
    foreach (regs[i]) wr(regs[i], 8'ha5 ^ 8'(i));
    wr(8'hc2, 8'hff);
    foreach (regs[i]) rc(regs[i], 8'ha5 ^ 8'(i), "reg rw");
    rc(8'hc2, 8'h00, "unmapped");
    foreach (regs[i]) wr(regs[i], 8'h00);
  endtask
  task automatic t_input;
    wr(BIOC_OPT_B, 8'h0c);
    wr(BIOC_DATA_B, 8'h0a);
    idle(3);
    chk("pull_up", 24'hfff5fc, pull_up);
    chk("analog_sel", 24'h000800, analog_sel);
    chk("drive_low_n", 24'hffffff, drive_low_n);
    chk("adc mux", 24'h2b, {18'h0, adc_mux_valid, adc_mux_sel});
  endtask
  task automatic t_irq;
    ext_en = 24'h000500;
    ext_val = 24'h000500;
    irq_trig_mode = 6'h33;
    idle(3);
    ext_val[8] = 1'b0;
    wirq(1'b0, "irq plain line");
    ext_val[10] = 1'b0;
    wirq(1'b1, "irq falling");
    irq_trig_mode = 6'h37;
    ext_val[10] = 1'b1;
    wirq(1'b1, "irq rising");
    irq_trig_mode = 6'h3b;
    ext_val[10] = 1'b0;
    wirq(1'b1, "irq low level");
  endtask
  task automatic t_inread;
    wr(BIOC_OPT_B, 8'h00);
    wr(BIOC_DATA_B, 8'h00);
    ext_en = 24'h00ffff;
    ext_val = 24'h003cff;
    idle(3);
    rc(BIOC_DATA_B, 8'h3c, "input read");
    rc(BIOC_DATA_A, 8'hfc, "port a read");
    chk("pull_up", 24'hfffffc, pull_up);
    wr(BIOC_DATA_B, 8'h0f);
    idle(3);
    chk("pull_up", 24'hfff0fc, pull_up);
    rc(BIOC_DATA_B, 8'h3c, "input read");
    wr(BIOC_DATA_B, 8'h00);
    ext_en = 24'h0;
  endtask
  task automatic t_output;
    wr(BIOC_DIR_C, 8'hff);
    wr(BIOC_OPT_C, 8'h0f);
    wr(BIOC_DATA_C, 8'h5a);
    idle(3);
    chk("drive_low_n", 24'h5affff, drive_low_n);
    chk("push_pull", 24'h0f0000, push_pull);
    chk("high_sink", 24'h0f0000, high_sink);
    rc(BIOC_DATA_C, 8'h5a, "output read");
  endtask
  task automatic t_alt;
    wr(BIOC_DIR_B, 8'h01);
    wr(BIOC_OPT_B, 8'h01);
    wr(BIOC_DATA_B, 8'h01);
    wr(BIOC_DIR_A, 8'h80);
    wr(BIOC_DATA_A, 8'h80);
    pwm_en = 1'b1;
    idle(3);
    chk("b7 b0 a7", 24'h2,
        24'({drive_low_n[15], drive_low_n[8], drive_low_n[7]}));
    pwm_lvl = 1'b1;
    sout = 1'b1;
    tx_act = 1'b1;
    idle(3);
    chk("b7 b0 a7", 24'h5,
        24'({drive_low_n[15], drive_low_n[8], drive_low_n[7]}));
    chk("b7 push_pull", 24'h1, 24'(push_pull[15]));
    pwm_en = 1'b0;
    tx_act = 1'b0;
    sout = 1'b0;
    wr(BIOC_OPT_A, 8'h80);
    idle(3);
    chk("b7 b0 a7", 24'h7,
        24'({drive_low_n[15], drive_low_n[8], drive_low_n[7]}));
    chk("high_sink b0 a7", 24'h1, 24'({high_sink[8], high_sink[7]}));
  endtask

  // ====
  // main
  initial begin
    do_reset();
    t_reset();
    t_regs();
    t_input();
    t_irq();
    t_inread();
    t_output();
    t_alt();
    ext_en = 24'h0;
    irq_trig_mode = 6'h3f;
    do_reset();
    t_reset();
    wrap_up();
  end
  // run takes well under 10 us
  initial begin
    #100us;
    fails++;
    wrap_up();
  end
endmodule // test_bytewise_io_port_config
